// ===== hdl/cnsg_consts.vh
// constants shared by the node state gating block
`ifndef CNSG_CONSTS_VH
`define CNSG_CONSTS_VH
// communication states
`define CNSG_ST_INIT      2'h0
`define CNSG_ST_PREOP     2'h1
`define CNSG_ST_OPER      2'h2
`define CNSG_ST_STOP      2'h3
// network-management command specifiers
`define CNSG_NMT_START    8'h01
`define CNSG_NMT_STOP     8'h02
`define CNSG_NMT_PREOP    8'h80
`define CNSG_NMT_RST_NODE 8'h81
`define CNSG_NMT_RST_COMM 8'h82
`define CNSG_NMT_BCAST    7'h00
// layer setting services
`define CNSG_LSS_WAIT     1'b0
`define CNSG_LSS_CONF     1'b1
`define CNSG_LSS_SW_GLOB  8'h04
`define CNSG_LSS_CFG_ID   8'h11
`define CNSG_LSS_CFG_BIT  8'h13
`define CNSG_LSS_STORE    8'h17
`define CNSG_LSS_OK       8'h00
`define CNSG_LSS_BAD      8'h01
// defaults and limits
`define CNSG_DEF_NODE_ID  7'h70
`define CNSG_DEF_BIT_IDX  4'h8
`define CNSG_MIN_NODE_ID  7'h01
`define CNSG_MAX_NODE_ID  7'h7f
`define CNSG_MAX_BIT_IDX  4'h8
// bit-rate codes, kbps
`define CNSG_KBPS_1000    11'h3e8
`define CNSG_KBPS_800     11'h320
`define CNSG_KBPS_500     11'h1f4
`define CNSG_KBPS_250     11'h0fa
`define CNSG_KBPS_125     11'h07d
`define CNSG_KBPS_100     11'h064
`define CNSG_KBPS_50      11'h032
`define CNSG_KBPS_20      11'h014
`define CNSG_KBPS_10      11'h00a
// process data word width in bits
`define CNSG_PDO_W        64
`endif

// ===== hdl/cnsg_pdo_store.v
// set-point store written only by accepted receive process data
`timescale 1ns/100ps
module cnsg_pdo_store #(
  parameter WIDTH = 64
) (
  input  wire             clk,
  input  wire             reset,
  input  wire             wr_en,
  input  wire [WIDTH-1:0] wr_data,
  output reg  [WIDTH-1:0] rd_data
);
  // registered output; reset clears set points to zero
  always @(posedge clk) begin
    if (reset) begin
      rd_data <= {WIDTH{1'b0}};
    end else if (wr_en) begin
      rd_data <= wr_data;
    end
  end
endmodule

// ===== hdl/cnsg_node.v
// network-management state, traffic gating and layer setting services of a CANopen node
`timescale 1ns/100ps
`include "cnsg_consts.vh"
module cnsg_node #(
  parameter PDO_W = `CNSG_PDO_W
) (
  input  wire             clk,
  input  wire             reset,
  input  wire             nmt_valid,
  input  wire [7:0]       nmt_cmd,
  input  wire [6:0]       nmt_target,
  input  wire             lss_valid,
  input  wire [7:0]       lss_cmd,
  input  wire [7:0]       lss_arg,
  input  wire             stored_valid,
  input  wire [6:0]       stored_node_id,
  input  wire [3:0]       stored_bit_idx,
  input  wire             sdo_req_valid,
  input  wire             sdo_req_status,
  input  wire             sdo_req_remap,
  input  wire [15:0]      sdo_req_data,
  output wire             sdo_req_ready,
  output reg              sdo_rsp_valid,
  output reg              sdo_rsp_abort,
  output reg  [15:0]      sdo_rsp_data,
  output reg  [15:0]      mode_out,
  input  wire             rpdo_valid,
  input  wire [PDO_W-1:0] rpdo_data,
  output wire             rpdo_ready,
  output wire [PDO_W-1:0] setpoint_out,
  input  wire             tpdo_trigger,
  input  wire [PDO_W-1:0] meas_in,
  output reg              tpdo_valid,
  output reg  [PDO_W-1:0] tpdo_data,
  output reg              lss_rsp_valid,
  output reg  [7:0]       lss_rsp_code,
  output wire [1:0]       nmt_state,
  output wire             lss_config,
  output wire [6:0]       node_id,
  output wire [3:0]       bit_idx,
  output reg  [10:0]      bit_rate_kbps,
  output reg              bootup_pulse
);
  reg  [1:0] state_reg;
  reg  [1:0] state_next;
  reg        lss_reg;
  reg  [6:0] id_reg;
  reg  [3:0] bit_reg;
  reg        defaults_pend_reg;
  wire       nmt_hit;
  wire       sdo_ok;
  wire       pdo_ok;
  wire       rpdo_we;
  wire [6:0] arg_id;

  assign nmt_state  = state_reg;
  assign lss_config = lss_reg;
  assign node_id    = id_reg;
  assign bit_idx    = bit_reg;
  assign arg_id     = lss_arg[6:0];

  //////////////////////////////////////////////////////////////////////////////
  // network-management state machine

  // command hits this node when addressed to it or broadcast
  assign nmt_hit = nmt_valid &&
                   ((nmt_target == id_reg) || (nmt_target == `CNSG_NMT_BCAST));

  // commands are decoded in every state but init, stopped included
  always @* begin
    state_next = state_reg;
    if (state_reg == `CNSG_ST_INIT) begin
      state_next = `CNSG_ST_PREOP; // boot-up finishes without master help
    end else if (nmt_hit) begin
      case (nmt_cmd)
        `CNSG_NMT_START:    state_next = `CNSG_ST_OPER;
        `CNSG_NMT_STOP:     state_next = `CNSG_ST_STOP;
        `CNSG_NMT_PREOP:    state_next = `CNSG_ST_PREOP;
        `CNSG_NMT_RST_NODE: state_next = `CNSG_ST_INIT;
        `CNSG_NMT_RST_COMM: state_next = `CNSG_ST_INIT;
        default:            state_next = state_reg; // unknown specifier ignored
      endcase
    end
  end

  // reset lands in init
  always @(posedge clk) begin
    if (reset) begin
      state_reg <= `CNSG_ST_INIT;
    end else begin
      state_reg <= state_next;
    end
  end

  // boot-up message once per entry into pre-operational from init
  always @(posedge clk) begin
    if (reset) begin
      bootup_pulse <= 1'b0;
    end else begin
      bootup_pulse <= (state_reg == `CNSG_ST_INIT);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // layer setting services

  // reset loads fixed defaults; valid in-range stored inputs replace them one cycle after reset release, never under reset
  always @(posedge clk) begin
    if (reset) begin
      lss_reg           <= `CNSG_LSS_WAIT;
      id_reg            <= `CNSG_DEF_NODE_ID;
      bit_reg           <= `CNSG_DEF_BIT_IDX;
      defaults_pend_reg <= 1'b1;
      lss_rsp_valid     <= 1'b0;
      lss_rsp_code      <= `CNSG_LSS_OK;
    end else begin
      defaults_pend_reg <= 1'b0;
      lss_rsp_valid     <= 1'b0;
      if (defaults_pend_reg && stored_valid) begin
        if ((stored_node_id >= `CNSG_MIN_NODE_ID) && (stored_bit_idx <= `CNSG_MAX_BIT_IDX)) begin
          id_reg  <= stored_node_id;
          bit_reg <= stored_bit_idx;
        end
      end else if (lss_valid) begin
        case (lss_cmd)
          `CNSG_LSS_SW_GLOB: begin
            lss_reg <= lss_arg[0] ? `CNSG_LSS_CONF : `CNSG_LSS_WAIT;
          end
          `CNSG_LSS_CFG_ID: begin
            if (lss_reg == `CNSG_LSS_CONF) begin // only while configuring
              lss_rsp_valid <= 1'b1;
              // range check; 0x80 and up fall outside the 7-bit field too
              if (!lss_arg[7] && (arg_id >= `CNSG_MIN_NODE_ID) &&
                  (arg_id <= `CNSG_MAX_NODE_ID)) begin
                id_reg       <= arg_id;
                lss_rsp_code <= `CNSG_LSS_OK;
              end else begin
                lss_rsp_code <= `CNSG_LSS_BAD;
              end
            end
          end
          `CNSG_LSS_CFG_BIT: begin
            if (lss_reg == `CNSG_LSS_CONF) begin
              lss_rsp_valid <= 1'b1;
              if (lss_arg <= {4'h0, `CNSG_MAX_BIT_IDX}) begin
                bit_reg      <= lss_arg[3:0];
                lss_rsp_code <= `CNSG_LSS_OK;
              end else begin
                lss_rsp_code <= `CNSG_LSS_BAD;
              end
            end
          end
          `CNSG_LSS_STORE: begin
            if (lss_reg == `CNSG_LSS_CONF) begin
              lss_rsp_valid <= 1'b1; // storage itself lies outside this block
              lss_rsp_code  <= `CNSG_LSS_OK;
            end
          end
          default: begin
            lss_rsp_valid <= 1'b0;
          end
        endcase
      end
    end
  end

  // bit-timing index to bus rate
  always @(posedge clk) begin
    if (reset) begin
      bit_rate_kbps <= `CNSG_KBPS_10;
    end else begin
      case (bit_reg)
        4'h0:    bit_rate_kbps <= `CNSG_KBPS_1000;
        4'h1:    bit_rate_kbps <= `CNSG_KBPS_800;
        4'h2:    bit_rate_kbps <= `CNSG_KBPS_500;
        4'h3:    bit_rate_kbps <= `CNSG_KBPS_250;
        4'h4:    bit_rate_kbps <= `CNSG_KBPS_125;
        4'h5:    bit_rate_kbps <= `CNSG_KBPS_100;
        4'h6:    bit_rate_kbps <= `CNSG_KBPS_50;
        4'h7:    bit_rate_kbps <= `CNSG_KBPS_20;
        default: bit_rate_kbps <= `CNSG_KBPS_10;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // traffic gating

  assign sdo_ok = (state_reg == `CNSG_ST_PREOP) || (state_reg == `CNSG_ST_OPER);
  assign pdo_ok = (state_reg == `CNSG_ST_OPER);

  // requests outside the allowed states are consumed and dropped silently
  assign sdo_req_ready = 1'b1;
  assign rpdo_ready    = 1'b1;
  assign rpdo_we       = rpdo_valid && pdo_ok; // set points only arrive this way

  // service data answered one cycle after the request, in pre-operational and operational only
  always @(posedge clk) begin
    if (reset) begin
      sdo_rsp_valid <= 1'b0;
      sdo_rsp_abort <= 1'b0;
      sdo_rsp_data  <= 16'h0000;
      mode_out      <= 16'h0000;
    end else begin
      sdo_rsp_valid <= sdo_req_valid && sdo_ok;
      sdo_rsp_abort <= 1'b0;
      if (sdo_req_valid && sdo_ok) begin
        if (sdo_req_remap) begin
          sdo_rsp_abort <= 1'b1; // fixed mapping, remap refused
          sdo_rsp_data  <= 16'h0000;
        end else if (sdo_req_status) begin
          sdo_rsp_data <= {4'h0, bit_reg, 1'b0, id_reg}; // status report
        end else begin
          mode_out     <= sdo_req_data; // operating-mode change
          sdo_rsp_data <= sdo_req_data;
        end
      end
    end
  end

  // measurements leave only in operational, copied from the node's own inputs
  always @(posedge clk) begin
    if (reset) begin
      tpdo_valid <= 1'b0;
      tpdo_data  <= {PDO_W{1'b0}};
    end else begin
      tpdo_valid <= tpdo_trigger && pdo_ok;
      if (tpdo_trigger && pdo_ok) begin
        tpdo_data <= meas_in;
      end
    end
  end

  // the store holds the last accepted set points
  cnsg_pdo_store #(
    .WIDTH (PDO_W)
  ) u_store (
    .clk     (clk),
    .reset   (reset),
    .wr_en   (rpdo_we),
    .wr_data (rpdo_data),
    .rd_data (setpoint_out)
  );
endmodule

// ===== sim/cnsg_node_properties.sv
// assertion checker for the node state gating block
`timescale 1ns/100ps
module cnsg_node_props #(
  parameter PDO_W = 64
) (
  input wire logic             clk,
  input wire logic             reset,
  input wire logic             nmt_valid,
  input wire logic [7:0]       nmt_cmd,
  input wire logic [6:0]       nmt_target,
  input wire logic             lss_valid,
  input wire logic [7:0]       lss_cmd,
  input wire logic [7:0]       lss_arg,
  input wire logic             sdo_req_valid,
  input wire logic             sdo_req_remap,
  input wire logic             sdo_rsp_valid,
  input wire logic             sdo_rsp_abort,
  input wire logic             tpdo_trigger,
  input wire logic [PDO_W-1:0] meas_in,
  input wire logic             tpdo_valid,
  input wire logic [PDO_W-1:0] tpdo_data,
  input wire logic             lss_rsp_valid,
  input wire logic [7:0]       lss_rsp_code,
  input wire logic [1:0]       nmt_state,
  input wire logic             lss_config,
  input wire logic [6:0]       node_id
);
  default clocking @(posedge clk); endclocking
  // reset is dropped on a clock edge, so the edge after still samples reset-time state
  logic rst_q;
  always @(posedge clk) rst_q <= reset;
  default disable iff (reset || rst_q);
  // a command counts when addressed to this node or broadcast, never while still in init
  wire hit = nmt_valid && nmt_state != 2'h0 && (nmt_target == 7'h00 || nmt_target == node_id);
  wire sdo_ok = nmt_state == 2'h1 || nmt_state == 2'h2;
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_set_id; lss_valid && lss_cmd == 8'h11 && lss_config; endsequence
  sequence s_id_ok; lss_arg >= 8'h01 && lss_arg <= 8'h7f; endsequence
  property p_boot; nmt_state == 2'h0 |=> nmt_state == 2'h1; endproperty
  property p_start; hit && nmt_cmd == 8'h01 |=> nmt_state == 2'h2; endproperty
  property p_stop; hit && nmt_cmd == 8'h02 |=> nmt_state == 2'h3; endproperty
  property p_wake; hit && nmt_state == 2'h3 && nmt_cmd == 8'h80 |=> nmt_state == 2'h1; endproperty
  property p_sdo; sdo_req_valid |=> sdo_rsp_valid == $past(sdo_ok); endproperty
  property p_remap; sdo_req_valid && sdo_req_remap && sdo_ok |=> sdo_rsp_abort; endproperty
  property p_tpdo;
    tpdo_trigger |=> tpdo_valid == ($past(nmt_state) == 2'h2) &&
      (!tpdo_valid || tpdo_data == $past(meas_in));
  endproperty
  property p_set_id;
    s_set_id ##0 s_id_ok |=> lss_rsp_valid && lss_rsp_code == 8'h00 &&
      {1'b0, node_id} == $past(lss_arg);
  endproperty
  a_boot: assert property (p_boot) else $error("init not left");
  a_start: assert property (p_start) else $error("start ignored");
  a_stop: assert property (p_stop) else $error("stop ignored");
  a_wake: assert property (p_wake) else $error("stopped node deaf");
  a_sdo: assert property (p_sdo) else $error("sdo gating wrong");
  a_remap: assert property (p_remap) else $error("remap accepted");
  a_tpdo: assert property (p_tpdo) else $error("tpdo wrong");
  a_set_id: assert property (p_set_id) else $error("id not set");
endmodule

bind cnsg_node cnsg_node_props #(.PDO_W(PDO_W)) u_props (.clk, .reset, .nmt_valid, .nmt_cmd,
  .nmt_target, .lss_valid, .lss_cmd, .lss_arg, .sdo_req_valid, .sdo_req_remap, .sdo_rsp_valid,
  .sdo_rsp_abort, .tpdo_trigger, .meas_in, .tpdo_valid, .tpdo_data, .lss_rsp_valid,
  .lss_rsp_code, .nmt_state, .lss_config, .node_id);

// ===== sim/cnsg_master_model.sv
// network master model issuing management and layer setting commands
`timescale 1ns/100ps
module cnsg_master (
  input  wire       clk,
  output reg        nmt_valid,
  output reg  [7:0] nmt_cmd,
  output reg  [6:0] nmt_target,
  output reg        lss_valid,
  output reg  [7:0] lss_cmd,
  output reg  [7:0] lss_arg
);
  initial {nmt_valid, nmt_cmd, nmt_target, lss_valid, lss_cmd, lss_arg} = '0;
  // one command pulse per call; commanded state changes come only from here
  task nmt(input logic [7:0] c, input logic [6:0] t);
    @(posedge clk);
    nmt_valid <= 1'b1;
    nmt_cmd <= c;
    nmt_target <= t;
    @(posedge clk);
    nmt_valid <= 1'b0;
    nmt_cmd <= ~c; // released fields must not look like a held command
  endtask
  // only one node sits on this bus while its identifier is set
  task lss(input logic [7:0] c, input logic [7:0] a);
    @(posedge clk);
    lss_valid <= 1'b1;
    lss_cmd <= c;
    lss_arg <= a;
    @(posedge clk);
    lss_valid <= 1'b0;
    lss_arg <= ~a;
  endtask
endmodule

// ===== sim/tb.sv
// self-checking bench for the node state gating block
`timescale 1ns/100ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_count++; \
  $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module tb;
  logic        clk, reset, stored_valid, sdo_req_valid, sdo_req_status, sdo_req_remap;
  logic        rpdo_valid, tpdo_trigger, nmt_valid, lss_valid, sdo_req_ready, sdo_rsp_valid;
  logic        sdo_rsp_abort, rpdo_ready, tpdo_valid, lss_rsp_valid, lss_config, bootup_pulse;
  logic [1:0]  nmt_state;
  logic [3:0]  stored_bit_idx, bit_idx;
  logic [6:0]  nmt_target, stored_node_id, node_id;
  logic [7:0]  nmt_cmd, lss_cmd, lss_arg, lss_rsp_code;
  logic [10:0] bit_rate_kbps;
  logic [15:0] sdo_req_data, sdo_rsp_data, mode_out;
  logic [63:0] rpdo_data, setpoint_out, meas_in, tpdo_data, sp_exp;
  logic [7:0]  row_cmd [8] = '{8'h01, 8'h02, 8'h80, 8'h01, 8'h01, 8'h02, 8'h01, 8'h55};
  logic [6:0]  row_tgt [8] = '{7'h00, 7'h70, 7'h00, 7'h71, 7'h70, 7'h00, 7'h70, 7'h70};
  logic [1:0]  row_st  [8] = '{2'h2, 2'h3, 2'h1, 2'h1, 2'h2, 2'h3, 2'h2, 2'h2};
  logic [10:0] rate    [9] = '{11'h3e8, 11'h320, 11'h1f4, 11'h0fa, 11'h07d, 11'h064, 11'h032,
                               11'h014, 11'h00a};
  int          err_count, checks, cyc;

  cnsg_node DUT (.*);
  cnsg_master u_master (.*);
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // whole run needs about 125 cycles; far more means a hang
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      err_count++;
      end_sim;
    end
  end
  task end_sim;
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // writes carry mode values only, never what process data also carries
  task sdo(input logic st, input logic rm, input logic [15:0] d);
    @(posedge clk);
    sdo_req_valid <= 1'b1;
    sdo_req_status <= st;
    sdo_req_remap <= rm;
    sdo_req_data <= d;
    @(posedge clk);
    sdo_req_valid <= 1'b0;
    #1;
  endtask
  task pdo(input logic [63:0] sp, input logic [63:0] ms);
    @(posedge clk);
    {rpdo_valid, tpdo_trigger} <= 2'b11;
    rpdo_data <= sp;
    meas_in <= ms;
    @(posedge clk);
    {rpdo_valid, tpdo_trigger} <= 2'b00;
    #1;
  endtask
  task lss(input logic [7:0] c, input logic [7:0] a);
    u_master.lss(c, a);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {reset, stored_valid, sdo_req_valid, sdo_req_status, sdo_req_remap} = 5'b10000;
    {rpdo_valid, tpdo_trigger, stored_node_id, stored_bit_idx} = '0;
    {sdo_req_data, rpdo_data, meas_in, sp_exp} = '0;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1;
    `CHK({nmt_state, bootup_pulse}, 3'h3)
    `CHK({node_id, bit_rate_kbps}, 18'h3_800a)
    `CHK({sdo_req_ready, rpdo_ready}, 2'h3)
    // each row: a command and the state it must give, then traffic gating; last row unknown
    for (int i = 0; i < 8; i++) begin
      u_master.nmt(row_cmd[i], row_tgt[i]);
      #1;
      `CHK(nmt_state, row_st[i])
      sdo(1'b0, 1'b0, 16'h0100 + i[15:0]);
      `CHK(sdo_rsp_valid, row_st[i] != 2'h3)
      if (row_st[i] != 2'h3) `CHK({mode_out, sdo_rsp_data}, {2{16'h0100 + i[15:0]}})
      pdo({32'h0000_a5a5, i}, {32'h0000_3c3c, i});
      `CHK(tpdo_valid, row_st[i] == 2'h2)
      if (row_st[i] == 2'h2) begin
        sp_exp = {32'h0000_a5a5, i};
        `CHK(tpdo_data, {32'h0000_3c3c, i})
      end
      `CHK(setpoint_out, sp_exp)
    end
    sdo(1'b0, 1'b1, 16'h0001);
    `CHK({sdo_rsp_abort, sdo_rsp_data}, 17'h1_0000)
    sdo(1'b1, 1'b0, 16'h0000);
    `CHK(sdo_rsp_data, 16'h0870)
    // configuration is ignored until the global switch, bad values refused
    lss(8'h11, 8'h71);
    `CHK(lss_rsp_valid, 1'b0)
    lss(8'h04, 8'h01);
    `CHK(lss_config, 1'b1)
    lss(8'h11, 8'h00);
    `CHK({lss_rsp_valid, lss_rsp_code}, 9'h101)
    lss(8'h11, 8'h80);
    `CHK({lss_rsp_valid, lss_rsp_code, node_id}, 16'h80f0)
    lss(8'h13, 8'h09);
    `CHK({lss_rsp_valid, lss_rsp_code}, 9'h101)
    lss(8'h11, 8'h7f);
    `CHK(node_id, 7'h7f)
    for (int i = 0; i < 9; i++) begin
      lss(8'h13, i[7:0]);
      @(posedge clk);
      #1;
      `CHK(bit_rate_kbps, rate[i])
    end
    lss(8'h17, 8'h00);
    `CHK({lss_rsp_valid, lss_rsp_code}, 9'h100)
    lss(8'h04, 8'h00);
    `CHK(lss_config, 1'b0)
    // new identifier selects the node; a reset keeps it and boots again
    u_master.nmt(8'h02, 7'h7f);
    #1;
    `CHK(nmt_state, 2'h3)
    u_master.nmt(8'h81, 7'h7f);
    #1;
    `CHK(nmt_state, 2'h0)
    @(posedge clk);
    #1;
    `CHK({nmt_state, node_id}, 9'h0ff)
    u_master.nmt(8'h82, 7'h00);
    #1;
    `CHK(nmt_state, 2'h0)
    // second reset with a valid stored configuration
    @(posedge clk);
    reset <= 1'b1;
    {stored_valid, stored_node_id, stored_bit_idx} <= {1'b1, 7'h22, 4'h3};
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    `CHK({node_id, bit_idx, bit_rate_kbps}, 22'h11_18fa)
    end_sim;
  end
endmodule
